/* fault_supervisor_pkg.sv */
// Shared constants and types for the fault protection supervisor
package fault_supervisor_pkg;

    // ============================================================
    // Clock and timing
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned NS_PER_US     = 1000;
    localparam int unsigned CYCLES_PER_US = NS_PER_US / CLK_PERIOD_NS;
    localparam logic [3:0]  RESTART_RISE_MULT = 4'h7;
    localparam logic [1:0]  OC_SHUT_COUNT     = 2'h3;

    // ============================================================
    // Junction temperature thresholds, degrees C
    localparam logic [7:0] JUNC_SHUT_C   = 8'ha0;
    localparam logic [7:0] JUNC_RESUME_C = 8'h8c;

    // ============================================================
    // Register word addresses
    localparam logic [7:0] ADDR_MODE                    = 8'h00;
    localparam logic [7:0] ADDR_OC_RESPONSE             = 8'h01;
    localparam logic [7:0] ADDR_VENDOR_WINDOW_LIMIT_CMD = 8'h02;
    localparam logic [7:0] ADDR_VIN_LIMITS              = 8'h03;
    localparam logic [7:0] ADDR_OT_LIMITS               = 8'h04;
    localparam logic [7:0] ADDR_RISE_TIME               = 8'h05;
    localparam logic [7:0] ADDR_STATUS                  = 8'h06;

    // ============================================================
    // Field positions
    localparam int unsigned LIM_LOW_POS  = 0;
    localparam int unsigned LIM_HIGH_POS = 8;
    localparam int unsigned LIM_UV_POS   = 16;
    localparam int unsigned LIM_OV_POS   = 24;
    localparam int unsigned PAIR_LO_POS  = 0;
    localparam int unsigned PAIR_HI_POS  = 8;

    // ============================================================
    // Reset values
    localparam logic [1:0]  RST_SLAVE      = 2'h0;
    localparam logic [1:0]  RST_LATCH      = 2'h0;
    localparam logic [31:0] RST_LIMITS     = 32'he6_a0_d2_b8;
    localparam logic [15:0] RST_VIN        = 16'h50_60;
    localparam logic [15:0] RST_OT         = 16'h64_7d;
    localparam logic [15:0] RST_RISE_US    = 16'h0bb8;

    // ============================================================
    // Channel states
    typedef enum logic [3:0] {
        ST_OFF, ST_SOFT, ST_RUN, ST_WAIT, ST_LATCH,
        ST_OVDIS, ST_OT, ST_JOT, ST_UVLO, ST_EXTW
    } chan_state_t;

endpackage : fault_supervisor_pkg

/* supervisor_reg_bank.sv */
// Register bank of the fault protection supervisor
`timescale 1ns/1ps
`default_nettype none
module supervisor_reg_bank
    import fault_supervisor_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [31:0] status_word,
    output logic      [31:0] reg_rdata,
    output logic      [1:0]  chan_slave,
    output logic      [1:0]  latch_resp,
    output logic      [31:0] limits,
    output logic      [15:0] vin_limits,
    output logic      [15:0] ot_limits,
    output logic      [15:0] rise_time_us
);

    typedef struct packed {
        logic [31:0] rdata;
        logic [1:0]  slave;
        logic [1:0]  latch;
        logic [31:0] limits;
        logic [15:0] vin;
        logic [15:0] ot;
        logic [15:0] rise;
    } bank_t;

    bank_t q;
    bank_t next_q;

    // ============================================================
    // Write and read decode
    always_comb begin
        next_q       = q;
        next_q.rdata = 32'h0;
        if (reg_wr) begin
            if (reg_addr == ADDR_MODE) begin
                next_q.slave = reg_wdata[1:0];
            end else if (reg_addr == ADDR_OC_RESPONSE) begin
                next_q.latch[0] = reg_wdata[0];
                if (!q.slave[1]) begin
                    next_q.latch[1] = reg_wdata[1];
                end
            end else if (reg_addr == ADDR_VENDOR_WINDOW_LIMIT_CMD) begin
                next_q.limits = reg_wdata;
            end else if (reg_addr == ADDR_VIN_LIMITS) begin
                next_q.vin = reg_wdata[15:0];
            end else if (reg_addr == ADDR_OT_LIMITS) begin
                next_q.ot = reg_wdata[15:0];
            end else if (reg_addr == ADDR_RISE_TIME) begin
                next_q.rise = reg_wdata[15:0];
            end
        end
        if (reg_rd) begin
            if (reg_addr == ADDR_MODE) begin
                next_q.rdata = {30'h0, q.slave};
            end else if (reg_addr == ADDR_OC_RESPONSE) begin
                next_q.rdata = {30'h0, latch_resp};
            end else if (reg_addr == ADDR_VENDOR_WINDOW_LIMIT_CMD) begin
                next_q.rdata = q.limits;
            end else if (reg_addr == ADDR_VIN_LIMITS) begin
                next_q.rdata = {16'h0, q.vin};
            end else if (reg_addr == ADDR_OT_LIMITS) begin
                next_q.rdata = {16'h0, q.ot};
            end else if (reg_addr == ADDR_RISE_TIME) begin
                next_q.rdata = {16'h0, q.rise};
            end else if (reg_addr == ADDR_STATUS) begin
                next_q.rdata = status_word;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '{rdata: 32'h0, slave: RST_SLAVE, latch: RST_LATCH,
                   limits: RST_LIMITS, vin: RST_VIN, ot: RST_OT, rise: RST_RISE_US};
        end else if (ce) begin
            q <= next_q;
        end
    end

    // ============================================================
    // Outputs
    assign reg_rdata    = q.rdata;
    assign chan_slave   = q.slave;
    assign latch_resp   = {q.slave[1] ? q.latch[0] : q.latch[1], q.latch[0]};
    assign limits       = q.limits;
    assign vin_limits   = q.vin;
    assign ot_limits    = q.ot;
    assign rise_time_us = q.rise;

endmodule : supervisor_reg_bank
`default_nettype wire

/* fault_protection_supervisor.sv */
// Fault supervision and power-good logic for two channels
//
// Contract
// - Power-good held low during soft-start
// - After soft-start, power-good follows window
// - Window and fault limits are programmable
// - Overcurrent truncates the current cycle
// - Three counted overcurrents shut channel down
// - Soft-start overcurrent only limits per cycle
// - Response: latch until run toggle, or restart
// - Slave channel two copies channel one response
// - Undervoltage shuts down like overcurrent
// - Overvoltage: high off, low on, fixed
// - After overvoltage, hard start in window
// - Only master feedback detects output faults
// - External overheat off, restart below hysteresis
// - Junction 160 stops, 140 soft-restarts
// - Input lockout with separate on/off thresholds
// - Faults except overvoltage and external pull drive channel fault line low
// - External fault pull shuts channel down
// - Shared line: restart after all release
// - Faults: high off, low only for overvoltage
// - Before soft-start only vin, OV, OT detect
// - Soft-start: no undervoltage; afterwards everything
// - Dual, two-phase and stacked modes supported
`timescale 1ns/1ps
`default_nettype none
module fault_protection_supervisor
    import fault_supervisor_pkg::*;
#(
    parameter int unsigned CYCLES_PER_US_P = CYCLES_PER_US
)
(
    input  wire logic            clk,
    input  wire logic            rst_b,
    input  wire logic            ce,
    input  wire logic [7:0]      reg_addr,
    input  wire logic [31:0]     reg_wdata,
    input  wire logic            reg_wr,
    input  wire logic            reg_rd,
    output logic      [31:0]     reg_rdata,
    input  wire logic [1:0]      channel_run_input,
    input  wire logic [1:0][7:0] feedback_sense_pin,
    input  wire logic [1:0][7:0] external_temp_sense_pin,
    input  wire logic [7:0]      junction_temp,
    input  wire logic [7:0]      vin_level,
    input  wire logic [1:0]      oc_event,
    input  wire logic [1:0]      cycle_end,
    input  wire logic [1:0]      soft_start_done,
    input  wire logic [1:0]      shared_fault_line_in,
    output logic      [1:0]      shared_fault_line_out,
    output logic      [1:0]      shared_fault_line_oe_b,
    input  wire logic [1:0]      power_good_in,
    output logic      [1:0]      power_good_out,
    output logic      [1:0]      power_good_oe_b,
    output logic      [1:0]      high_side_en,
    output logic      [1:0]      low_side_en,
    output logic      [1:0]      pwm_tristate,
    output logic      [1:0]      cycle_truncate,
    output logic      [1:0]      soft_start_go,
    output logic      [1:0]      hard_start_go,
    output logic                 junction_overheat_fault
);

    // ============================================================
    // Helpers
    function automatic logic in_window(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
        in_window = (v >= lo) && (v <= hi);
    endfunction : in_window

    function automatic logic [31:0] restart_cycles(input logic [15:0] rise_us);
        restart_cycles = 32'(RESTART_RISE_MULT) * 32'(rise_us) * 32'(CYCLES_PER_US_P);
    endfunction : restart_cycles

    // ============================================================
    // State
    typedef struct packed {
        chan_state_t [1:0]       st;
        logic        [1:0][1:0]  oc_cnt;
        logic        [1:0]       oc_pend;
        logic        [1:0][31:0] dly;
        logic        [1:0]       ss_go;
        logic        [1:0]       hard_go;
        logic                    vin_armed;
        logic                    jot;
    } sup_t;

    sup_t q;
    sup_t next_q;

    logic [1:0]  chan_slave;
    logic [1:0]  latch_resp;
    logic [31:0] limits;
    logic [15:0] vin_limits;
    logic [15:0] ot_limits;
    logic [15:0] rise_time_us;
    logic [31:0] status_word;

    logic [7:0] window_low_limit;
    logic [7:0] window_high_limit;
    logic [7:0] uv_limit;
    logic [7:0] ov_limit;

    // ============================================================
    // Register bank
    supervisor_reg_bank u_regs (
        .clk          (clk),
        .rst_b        (rst_b),
        .ce           (ce),
        .reg_addr     (reg_addr),
        .reg_wdata    (reg_wdata),
        .reg_wr       (reg_wr),
        .reg_rd       (reg_rd),
        .status_word  (status_word),
        .reg_rdata    (reg_rdata),
        .chan_slave   (chan_slave),
        .latch_resp   (latch_resp),
        .limits       (limits),
        .vin_limits   (vin_limits),
        .ot_limits    (ot_limits),
        .rise_time_us (rise_time_us)
    );

    assign window_low_limit  = limits[LIM_LOW_POS +: 8];
    assign window_high_limit = limits[LIM_HIGH_POS +: 8];
    assign uv_limit          = limits[LIM_UV_POS +: 8];
    assign ov_limit          = limits[LIM_OV_POS +: 8];

    // ============================================================
    // Per-channel sensing
    logic [1:0] own_uv;
    logic [1:0] own_ov;
    logic [1:0] own_win;
    logic [1:0] uv_eff;
    logic [1:0] ov_eff;
    logic [1:0] win_eff;
    logic [1:0] self_drive;
    logic [1:0] ext_pull;
    logic [1:0] ot_hot;
    logic [1:0] ot_cool;
    logic [1:0] oc_hit;
    logic       vin_fault;

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            own_uv[i]  = feedback_sense_pin[i] < uv_limit;
            own_ov[i]  = feedback_sense_pin[i] > ov_limit;
            own_win[i] = in_window(feedback_sense_pin[i], window_low_limit, window_high_limit);
            ot_hot[i]  = external_temp_sense_pin[i] > ot_limits[PAIR_LO_POS +: 8];
            ot_cool[i] = external_temp_sense_pin[i] < ot_limits[PAIR_HI_POS +: 8];
            oc_hit[i]  = oc_event[i] || q.oc_pend[i];
            self_drive[i] = (q.st[i] == ST_LATCH) || (q.st[i] == ST_OT) || (q.st[i] == ST_JOT)
                            || (q.st[i] == ST_UVLO) || ((q.st[i] == ST_WAIT) && (q.dly[i] != 32'h0));
            ext_pull[i] = !shared_fault_line_in[i] && !self_drive[i];
        end
        uv_eff[0]  = chan_slave[0] ? 1'b0 : own_uv[0];
        ov_eff[0]  = chan_slave[0] ? 1'b0 : own_ov[0];
        win_eff[0] = own_win[0];
        uv_eff[1]  = chan_slave[1] ? (!chan_slave[0] && own_uv[0]) : own_uv[1];
        ov_eff[1]  = chan_slave[1] ? (!chan_slave[0] && own_ov[0]) : own_ov[1];
        win_eff[1] = chan_slave[1] ? own_win[0] : own_win[1];
    end

    // Fall below off after passing on
    assign vin_fault = q.vin_armed && (vin_level < vin_limits[PAIR_HI_POS +: 8]);

    // ============================================================
    // Channel sequencing
    always_comb begin
        next_q         = q;
        next_q.ss_go   = 2'h0;
        next_q.hard_go = 2'h0;
        if (vin_level >= vin_limits[PAIR_LO_POS +: 8]) begin
            next_q.vin_armed = 1'b1;
        end else if (vin_fault) begin
            next_q.vin_armed = 1'b0;
        end
        if (junction_temp >= JUNC_SHUT_C) begin
            next_q.jot = 1'b1;
        end else if (junction_temp <= JUNC_RESUME_C) begin
            next_q.jot = 1'b0;
        end
        for (int i = 0; i < 2; i++) begin
            if (oc_event[i]) begin
                next_q.oc_pend[i] = 1'b1;
            end
            if (cycle_end[i]) begin
                next_q.oc_pend[i] = 1'b0;
            end
            if (q.st[i] != ST_RUN) begin
                next_q.oc_cnt[i] = 2'h0;
            end
            case (q.st[i])
                ST_OFF: begin
                    if (vin_fault) begin
                        next_q.st[i] = ST_UVLO;
                    end else if (ov_eff[i]) begin
                        next_q.st[i] = ST_OVDIS;
                    end else if (ot_hot[i]) begin
                        next_q.st[i] = ST_OT;
                    end else if (channel_run_input[i] && q.vin_armed && !q.jot) begin
                        next_q.st[i]    = ST_SOFT;
                        next_q.ss_go[i] = 1'b1;
                    end
                end
                ST_SOFT, ST_RUN: begin
                    if (vin_fault) begin
                        next_q.st[i] = ST_UVLO;
                    end else if (ov_eff[i]) begin
                        next_q.st[i] = ST_OVDIS;
                    end else if (q.jot) begin
                        next_q.st[i] = ST_JOT;
                    end else if (ot_hot[i]) begin
                        next_q.st[i] = ST_OT;
                    end else if (ext_pull[i]) begin
                        next_q.st[i] = ST_EXTW;
                    end else if (q.st[i] == ST_SOFT) begin
                        if (soft_start_done[i]) begin
                            next_q.st[i] = ST_RUN;
                        end
                    end else if (uv_eff[i] || (cycle_end[i] && oc_hit[i] && q.oc_cnt[i] == OC_SHUT_COUNT - 2'h1)) begin
                        if (latch_resp[i]) begin
                            next_q.st[i] = ST_LATCH;
                        end else begin
                            next_q.st[i]  = ST_WAIT;
                            next_q.dly[i] = restart_cycles(rise_time_us);
                        end
                    end else if (cycle_end[i]) begin
                        next_q.oc_cnt[i] = oc_hit[i] ? q.oc_cnt[i] + 2'h1 : 2'h0;
                    end
                end
                ST_WAIT: begin
                    if (q.dly[i] != 32'h0) begin
                        next_q.dly[i] = q.dly[i] - 32'h1;
                    end else if (shared_fault_line_in[i] && !uv_eff[i] && q.vin_armed) begin
                        next_q.st[i]    = ST_SOFT;
                        next_q.ss_go[i] = 1'b1;
                    end
                end
                ST_OVDIS: begin
                    if (win_eff[i] && !ov_eff[i]) begin
                        next_q.st[i]      = ST_RUN;
                        next_q.hard_go[i] = 1'b1;
                    end
                end
                ST_OT, ST_JOT, ST_UVLO, ST_EXTW: begin
                    if ((q.st[i] == ST_OT && ot_cool[i]) || (q.st[i] == ST_JOT && !q.jot)
                        || (q.st[i] == ST_UVLO && q.vin_armed)
                        || (q.st[i] == ST_EXTW && shared_fault_line_in[i])) begin
                        next_q.st[i]    = ST_SOFT;
                        next_q.ss_go[i] = 1'b1;
                    end
                end
                default: begin
                    next_q.st[i] = q.st[i];
                end
            endcase
            if (!channel_run_input[i]) begin
                next_q.st[i]    = ST_OFF;
                next_q.ss_go[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '{st: '{ST_OFF, ST_OFF}, oc_cnt: 4'h0, oc_pend: 2'h0, dly: 64'h0,
                   ss_go: 2'h0, hard_go: 2'h0, vin_armed: 1'b0, jot: 1'b0};
        end else if (ce) begin
            q <= next_q;
        end
    end

    // ============================================================
    // Outputs
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            high_side_en[i] = (q.st[i] == ST_SOFT) || (q.st[i] == ST_RUN);
            low_side_en[i]  = high_side_en[i] || (q.st[i] == ST_OVDIS);
            pwm_tristate[i] = !low_side_en[i];
            cycle_truncate[i] = high_side_en[i] && oc_event[i];
            // Released only when running in window
            power_good_oe_b[i] = (q.st[i] == ST_RUN) && win_eff[i];
            shared_fault_line_oe_b[i] = !self_drive[i];
        end
    end

    assign power_good_out          = 2'h0;
    assign shared_fault_line_out   = 2'h0;
    assign soft_start_go           = q.ss_go;
    assign hard_start_go           = q.hard_go;
    assign junction_overheat_fault = q.jot;
    assign status_word = {14'h0, power_good_in, shared_fault_line_in, q.vin_armed, q.jot,
                          q.oc_cnt[1], q.oc_cnt[0], 4'(q.st[1]), 4'(q.st[0])};

    // ============================================================
    // Assertions
    for (genvar g = 0; g < 2; g++) begin : g_chk
        a_pg_soft_low: assert property (@(posedge clk) disable iff (!rst_b)
            q.st[g] == ST_SOFT |-> !power_good_oe_b[g]) else $error("power good released in soft-start");
        a_pg_window: assert property (@(posedge clk) disable iff (!rst_b)
            (q.st[g] == ST_RUN && !win_eff[g]) |-> !power_good_oe_b[g]) else $error("power good outside window");
        a_oc_third_shut: assert property (@(posedge clk) disable iff (!rst_b)
            (ce && channel_run_input[g] && q.st[g] == ST_RUN && cycle_end[g] && oc_hit[g] && q.oc_cnt[g] == 2'h2)
            |=> q.st[g] != ST_RUN) else $error("third overcurrent did not shut down");
        a_soft_no_count: assert property (@(posedge clk) disable iff (!rst_b)
            q.st[g] == ST_SOFT |-> q.oc_cnt[g] == 2'h0) else $error("overcurrent counted in soft-start");
        a_ov_discharge: assert property (@(posedge clk) disable iff (!rst_b)
            q.st[g] == ST_OVDIS |-> (low_side_en[g] && !high_side_en[g] && !pwm_tristate[g]))
            else $error("overvoltage drive wrong");
        a_ov_hard_start: assert property (@(posedge clk) disable iff (!rst_b)
            ($past(q.st[g]) == ST_OVDIS && q.st[g] == ST_RUN) |-> hard_start_go[g] && !soft_start_go[g])
            else $error("no hard start after overvoltage");
        a_latch_pulls: assert property (@(posedge clk) disable iff (!rst_b)
            q.st[g] == ST_LATCH |-> !shared_fault_line_oe_b[g] && pwm_tristate[g])
            else $error("latched fault not on fault line");
        a_ext_shut: assert property (@(posedge clk) disable iff (!rst_b)
            (ce && channel_run_input[g] && q.st[g] == ST_RUN && ext_pull[g] && !vin_fault && !ov_eff[g]
             && !q.jot && !ot_hot[g]) |=> q.st[g] == ST_EXTW ##0 !high_side_en[g])
            else $error("external pull ignored");
        c_hiccup: cover property (@(posedge clk) disable iff (!rst_b) q.st[g] == ST_WAIT ##1 q.st[g] == ST_SOFT);
        c_ov_cycle: cover property (@(posedge clk) disable iff (!rst_b) q.st[g] == ST_OVDIS ##1 q.st[g] == ST_RUN);
        c_latch: cover property (@(posedge clk) disable iff (!rst_b) q.st[g] == ST_LATCH);
    end

endmodule : fault_protection_supervisor
`default_nettype wire

/* pin_pullup_model.sv */
// Pull-up model of the shared fault lines and power-good pins
`timescale 1ns/1ps
`default_nettype none
module pin_pullup_model (
    input  wire logic [1:0] fault_oe_b,
    input  wire logic [1:0] fault_ext_pull,
    input  wire logic [1:0] pg_oe_b,
    output logic      [1:0] fault_line,
    output logic      [1:0] pg_line
);
    // ============================================================
    // Open-drain lines
    // Wired-and fault line
    assign fault_line = fault_oe_b & ~fault_ext_pull;
    assign pg_line    = pg_oe_b;
endmodule : pin_pullup_model
`default_nettype wire

/* tb_fault_protection_supervisor.sv */
// Self-checking testbench of the fault protection supervisor
`timescale 1ns/1ps
`default_nettype none
module tb_fault_protection_supervisor;
    import fault_supervisor_pkg::*;
    logic            clk = '0, rst_b = '0, reg_wr = '0, reg_rd = '0, ce = '1, jof;
    logic [7:0]      reg_addr = '0, jt = 8'h19;
    logic [31:0]     reg_wdata = '0, reg_rdata, d;
    logic [1:0]      run = '0, oc = '0, cend = '0, ssd = '0, ext_pull = '0;
    logic [1:0][7:0] fb = {8'hc4, 8'hc4};
    logic [1:0]      flt_in, flt_oe_b, pg_in, pg_oe_b, hs, ls, tri_s, trunc, ssgo, hsgo;
    int              miscompares = 0, tests_run = 0, n;
    fault_protection_supervisor #(.CYCLES_PER_US_P(1)) dut (.clk, .rst_b, .ce, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .channel_run_input(run), .feedback_sense_pin(fb),
        .external_temp_sense_pin({8'h30, 8'h30}), .junction_temp(jt), .vin_level(8'h80), .oc_event(oc),
        .cycle_end(cend), .soft_start_done(ssd), .shared_fault_line_in(flt_in), .shared_fault_line_out(),
        .shared_fault_line_oe_b(flt_oe_b), .power_good_in(pg_in), .power_good_out(), .power_good_oe_b(pg_oe_b),
        .high_side_en(hs), .low_side_en(ls), .pwm_tristate(tri_s), .cycle_truncate(trunc),
        .soft_start_go(ssgo), .hard_start_go(hsgo), .junction_overheat_fault(jof));
    pin_pullup_model far (.fault_oe_b(flt_oe_b), .fault_ext_pull(ext_pull), .pg_oe_b(pg_oe_b),
        .fault_line(flt_in), .pg_line(pg_in));
    initial forever #10 clk = ~clk;
    task automatic step;
        @(posedge clk);
        #1;
    endtask : step
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'h1;
        step();
        reg_wr <= 1'h0;
        step();
    endtask : wr
    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        reg_rd <= 1'h1;
        step();
        reg_rd <= 1'h0;
        d = reg_rdata;
        step();
    endtask : rd
    task automatic wait_go(input int lim);
        n = 0;
        while (ssgo[0] !== 1'h1 && n < lim) begin
            step();
            n++;
        end
        chk("soft_start_go", 1, ssgo[0]);
        ssd[0] <= 1'h1;
        step();
        ssd[0] <= 1'h0;
    endtask : wait_go
    task automatic s_regs;
        rd(ADDR_VENDOR_WINDOW_LIMIT_CMD);
        chk("limits", RST_LIMITS, d);
        rd(8'h7f);
        chk("unmapped", 0, d);
        wr(ADDR_RISE_TIME, 32'h2);
        rd(ADDR_RISE_TIME);
        chk("rise", 32'h2, d);
        ce <= 1'h0;
        rd(ADDR_RISE_TIME);
        chk("ce freeze", 0, d);
        ce <= 1'h1;
        wr(ADDR_MODE, 32'h2);
        wr(ADDR_OC_RESPONSE, 32'h1);
        rd(ADDR_OC_RESPONSE);
        chk("slave resp", 32'h3, d);
        wr(ADDR_OC_RESPONSE, 32'h2);
        wr(ADDR_MODE, 32'h0);
        rd(ADDR_OC_RESPONSE);
        chk("slave lock", 32'h0, d);
    endtask : s_regs
    task automatic s_start;
        run[0] <= 1'h1;
        step();
        chk("pg soft", 0, pg_oe_b[0]);
        wait_go(20);
        step();
        chk("pg in", 1, pg_oe_b[0]);
        fb[0] <= 8'hb0;
        step();
        chk("pg out", 0, pg_oe_b[0]);
        fb[0] <= 8'hc4;
    endtask : s_start
    task automatic s_oc;
        oc[0] <= 1'h1;
        step();
        chk("truncate", 1, trunc[0]);
        repeat (3) begin
            cend[0] <= 1'h1;
            step();
            cend[0] <= 1'h0;
            step();
        end
        oc[0] <= 1'h0;
        chk("drive", 3'b010, {hs[0], tri_s[0], ls[0]});
        chk("fault pull", 0, flt_oe_b[0]);
        wait_go(60);
        chk("delay", 1, n >= 13 && n <= 18);
    endtask : s_oc
    task automatic s_ov;
        fb[0] <= 8'hf0;
        step();
        step();
        chk("ov drive", 3'b001, {hs[0], tri_s[0], ls[0]});
        fb[0] <= 8'hc4;
        n = 0;
        while (hsgo[0] !== 1'h1 && n < 5) begin
            step();
            n++;
        end
        chk("hard start", 1, hsgo[0]);
    endtask : s_ov
    task automatic s_ext;
        ext_pull[0] <= 1'h1;
        step();
        chk("ext drive", 3'b010, {hs[0], tri_s[0], ls[0]});
        step();
        chk("ext held", 3'b010, {hs[0], tri_s[0], ls[0]});
        ext_pull[0] <= 1'h0;
        wait_go(5);
    endtask : s_ext
    task automatic s_jot;
        jt <= 8'ha0;
        step();
        step();
        chk("jot stop", 4'b1010, {jof, hs[0], tri_s[0], ls[0]});
        jt <= 8'h96;
        step();
        chk("jot hold", 1, jof);
        jt <= 8'h8c;
        wait_go(5);
    endtask : s_jot
    task automatic summarize;
        $display("Checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize
    initial begin
        #200000;
        miscompares++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'h1;
        step();
        s_regs();
        s_start();
        s_oc();
        s_ov();
        s_ext();
        s_jot();
        summarize();
    end
endmodule : tb_fault_protection_supervisor
`default_nettype wire
